// ==== verilog/npa_host.v ====
// NAND host pin sequencer with address packing and factory bad-block scan
`timescale 1ns/1ps
`default_nettype none
`include "npa_consts.vh"
module npa_host (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_x16,
  input wire i_wp_release,
  input wire i_op_valid,
  output wire o_op_ready,
  input wire [2:0] i_op_code,
  input wire [7:0] i_op_byte,
  input wire [11:0] i_op_col,
  input wire [15:0] i_op_row,
  input wire [11:0] i_op_count,
  input wire i_wr_valid,
  output wire o_wr_ready,
  input wire [15:0] i_wr_data,
  output wire o_rd_valid,
  input wire i_rd_ready,
  output wire [15:0] o_rd_data,
  output wire o_rd_bad,
  output wire o_busy,
  output wire o_ce_n,
  output wire o_cle,
  output wire o_ale,
  output wire o_we_n,
  output wire o_read_strobe_n,
  output wire o_wp_n,
  input wire i_ready_busy,
  input wire [7:0] i_io_low_byte,
  output wire [7:0] o_io_low_byte,
  output wire o_io_low_byte_oe,
  input wire [7:0] i_io_high_byte,
  output wire [7:0] o_io_high_byte,
  output wire o_io_high_byte_oe
);
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_CMD = 9'h002;
  localparam [8:0] S_ADDR = 9'h004;
  localparam [8:0] S_WSTART = 9'h008;
  localparam [8:0] S_WRITE = 9'h010;
  localparam [8:0] S_RSTART = 9'h020;
  localparam [8:0] S_READ = 9'h040;
  localparam [8:0] S_WAIT = 9'h080;
  localparam [8:0] S_SCAN = 9'h100;
  localparam integer STROBE_CYC = `NPA_STROBE_CYC - 1;
  localparam integer WB_CYC = `NPA_WB_CYC - 1;
  localparam [3:0] STROBE_LEN = STROBE_CYC[3:0];
  localparam [3:0] WB_LEN = WB_CYC[3:0];

  reg [8:0] state_q;
  reg [3:0] tmr_q;
  reg half_q;
  reg [1:0] acnt_q;
  reg [11:0] cnt_q;
  reg [11:0] col_q;
  reg [15:0] row_q;
  reg scan_q;
  reg [2:0] step_q;
  reg [1:0] sub_q;
  reg [9:0] blk_q;
  reg bad_q;
  reg ce_n_q;
  reg cle_q;
  reg ale_q;
  reg we_n_q;
  reg re_n_q;
  reg wp_n_q;
  reg [15:0] dout_q;
  reg oe_lo_q;
  reg oe_hi_q;

  wire fifo_in_ready;
  wire [16:0] fifo_out;
  wire [3:0] ones [0:8];
  wire [11:0] scan_col = sub_q[0] ? (i_x16 ? `NPA_SPARE_COL_X16 : `NPA_SPARE_COL_X8)
                                   : 12'h000;
  wire [15:0] scan_row = {blk_q, sub_q[1] ? `NPA_LAST_PAGE : 6'h00};
  wire sample = (state_q == S_READ) && (tmr_q == 4'h0) && !half_q;
  wire data_push = sample && !scan_q;
  wire scan_push = (state_q == S_SCAN) && (step_q == 3'h5) && (sub_q == 2'h3) &&
                   bad_q && fifo_in_ready;

  // Marker popcount; only the low lane is examined, the marker being a byte
  genvar g;
  assign ones[0] = 4'h0;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pop
      assign ones[g+1] = ones[g] + {3'h0, i_io_low_byte[g]};
    end
  endgenerate

  // Four address bytes; row layout is the same for both organisations
  function [7:0] addr_byte;
    input [1:0] n;
    input [11:0] col;
    input [15:0] row;
    input x16;
    begin
      case (n)
        2'h0: addr_byte = col[7:0];
        2'h1: addr_byte = x16 ? {5'h00, col[10:8]} : {4'h0, col[11:8]};
        2'h2: addr_byte = row[7:0];
        default: addr_byte = row[15:8];
      endcase
    end
  endfunction

  task finish_op;
    begin
      if (scan_q) begin
        state_q <= S_SCAN;
        step_q <= step_q + 3'h1;
      end else begin
        state_q <= S_IDLE;
        ce_n_q <= 1'b1;
      end
    end
  endtask

  task start_cmd;
    input [7:0] c;
    begin
      dout_q <= {8'h00, c};
      cle_q <= 1'b1;
      oe_lo_q <= 1'b1;
      we_n_q <= 1'b0;
      half_q <= 1'b0;
      tmr_q <= STROBE_LEN;
      state_q <= S_CMD;
    end
  endtask

  task start_addr;
    input [11:0] col;
    input [15:0] row;
    begin
      col_q <= col;
      row_q <= row;
      acnt_q <= 2'h0;
      dout_q <= {8'h00, addr_byte(2'h0, col, row, i_x16)};
      ale_q <= 1'b1;
      oe_lo_q <= 1'b1;
      we_n_q <= 1'b0;
      half_q <= 1'b0;
      tmr_q <= STROBE_LEN;
      state_q <= S_ADDR;
    end
  endtask

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= S_IDLE;
      tmr_q <= 4'h0;
      half_q <= 1'b0;
      acnt_q <= 2'h0;
      cnt_q <= 12'h000;
      col_q <= 12'h000;
      row_q <= 16'h0000;
      scan_q <= 1'b0;
      step_q <= 3'h0;
      sub_q <= 2'h0;
      blk_q <= 10'h000;
      bad_q <= 1'b0;
      ce_n_q <= 1'b1;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      we_n_q <= 1'b1;
      re_n_q <= 1'b1;
      wp_n_q <= 1'b0;
      dout_q <= 16'h0000;
      oe_lo_q <= 1'b0;
      oe_hi_q <= 1'b0;
    end else begin
      // Protection is only lifted outside a scan so the scan can never alter the array
      // The scan's own take edge counts too, else protection lifts for one cycle
      wp_n_q <= i_wp_release && !scan_q &&
                !((state_q == S_IDLE) && i_op_valid && (i_op_code == `NPA_OP_SCAN));
      case (state_q)
        S_IDLE: begin
          if (i_op_valid) begin
            cnt_q <= i_op_count;
            ce_n_q <= 1'b0;
            case (i_op_code)
              `NPA_OP_CMD: start_cmd(i_op_byte);
              `NPA_OP_ADDR: start_addr(i_op_col, i_op_row);
              `NPA_OP_WRITE: state_q <= S_WSTART;
              `NPA_OP_READ: state_q <= S_RSTART;
              `NPA_OP_WAIT: begin
                tmr_q <= WB_LEN;
                state_q <= S_WAIT;
              end
              `NPA_OP_SCAN: begin
                scan_q <= 1'b1;
                blk_q <= 10'h000;
                sub_q <= 2'h0;
                step_q <= 3'h0;
                bad_q <= 1'b0;
                state_q <= S_SCAN;
              end
              default: ce_n_q <= 1'b1;
            endcase
          end
        end
        S_CMD, S_ADDR, S_WRITE: begin
          if (tmr_q != 4'h0) begin
            tmr_q <= tmr_q - 4'h1;
          end else if (!half_q) begin
            we_n_q <= 1'b1;
            half_q <= 1'b1;
            tmr_q <= STROBE_LEN;
          end else if (state_q == S_ADDR && acnt_q != `NPA_ADDR_CYCLES) begin
            acnt_q <= acnt_q + 2'h1;
            dout_q <= {8'h00, addr_byte(acnt_q + 2'h1, col_q, row_q, i_x16)};
            we_n_q <= 1'b0;
            half_q <= 1'b0;
            tmr_q <= STROBE_LEN;
          end else begin
            cle_q <= 1'b0;
            ale_q <= 1'b0;
            oe_lo_q <= 1'b0;
            oe_hi_q <= 1'b0;
            if (state_q == S_WRITE) begin
              cnt_q <= cnt_q - 12'h001;
              state_q <= S_WSTART;
            end else begin
              finish_op;
            end
          end
        end
        S_WSTART: begin
          if (cnt_q == 12'h000) begin
            finish_op;
          end else if (i_wr_valid) begin
            dout_q <= i_x16 ? i_wr_data : {8'h00, i_wr_data[7:0]};
            oe_lo_q <= 1'b1;
            oe_hi_q <= i_x16;
            we_n_q <= 1'b0;
            half_q <= 1'b0;
            tmr_q <= STROBE_LEN;
            state_q <= S_WRITE;
          end
        end
        S_RSTART: begin
          // Outside a scan, starting a word only with FIFO room means the sample can never be dropped
          if (cnt_q == 12'h000) begin
            finish_op;
          end else if (fifo_in_ready || scan_q) begin
            re_n_q <= 1'b0;
            half_q <= 1'b0;
            tmr_q <= STROBE_LEN;
            state_q <= S_READ;
          end
        end
        S_READ: begin
          if (tmr_q != 4'h0) begin
            tmr_q <= tmr_q - 4'h1;
          end else if (!half_q) begin
            re_n_q <= 1'b1;
            half_q <= 1'b1;
            tmr_q <= STROBE_LEN;
            if (scan_q && ones[8] <= `NPA_MARK_MAX_ONES) begin
              bad_q <= 1'b1;
            end
          end else begin
            cnt_q <= cnt_q - 12'h001;
            state_q <= S_RSTART;
          end
        end
        S_WAIT: begin
          if (tmr_q != 4'h0) begin
            tmr_q <= tmr_q - 4'h1;
          end else if (i_ready_busy) begin
            finish_op;
          end
        end
        S_SCAN: begin
          case (step_q)
            3'h0: start_cmd(`NPA_CMD_READ_SETUP);
            3'h1: start_addr(scan_col, scan_row);
            3'h2: start_cmd(`NPA_CMD_READ_GO);
            3'h3: begin
              tmr_q <= WB_LEN;
              state_q <= S_WAIT;
            end
            3'h4: begin
              cnt_q <= 12'h001;
              state_q <= S_RSTART;
            end
            3'h5: begin
              if (sub_q != 2'h3) begin
                sub_q <= sub_q + 2'h1;
                step_q <= 3'h0;
              end else if (!bad_q || fifo_in_ready) begin
                bad_q <= 1'b0;
                sub_q <= 2'h0;
                step_q <= 3'h0;
                if (blk_q == `NPA_LAST_BLOCK) begin
                  scan_q <= 1'b0;
                  ce_n_q <= 1'b1;
                  state_q <= S_IDLE;
                end else begin
                  blk_q <= blk_q + 10'h001;
                end
              end
            end
            default: state_q <= S_IDLE;
          endcase
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  npa_fifo #(
    .W(`NPA_FIFO_WIDTH),
    .D(`NPA_FIFO_DEPTH),
    .AW(`NPA_FIFO_AW)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(data_push || scan_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(scan_push ? {1'b1, 6'h00, blk_q}
                         : {1'b0, (i_x16 ? i_io_high_byte : 8'h00), i_io_low_byte}),
    .o_out_valid(o_rd_valid),
    .i_out_ready(i_rd_ready),
    .o_out_data(fifo_out)
  );

  assign o_op_ready = (state_q == S_IDLE);
  assign o_wr_ready = (state_q == S_WSTART) && (cnt_q != 12'h000);
  assign o_rd_data = fifo_out[15:0];
  assign o_rd_bad = fifo_out[16];
  assign o_busy = (state_q != S_IDLE);
  assign o_ce_n = ce_n_q;
  assign o_cle = cle_q;
  assign o_ale = ale_q;
  assign o_we_n = we_n_q;
  assign o_read_strobe_n = re_n_q;
  assign o_wp_n = wp_n_q;
  assign o_io_low_byte = dout_q[7:0];
  assign o_io_low_byte_oe = oe_lo_q;
  assign o_io_high_byte = dout_q[15:8];
  assign o_io_high_byte_oe = oe_hi_q;
endmodule // npa_host
`default_nettype wire

// ==== pkg/npa_consts.vh ====
// Constants for the NAND pin-level host sequencer and bad-block scanner
`ifndef NPA_CONSTS_VH
`define NPA_CONSTS_VH

`define NPA_CLK_PERIOD_NS 50
`define NPA_T_STROBE_NS 50
`define NPA_T_WB_NS 100
`define NPA_STROBE_CYC ((`NPA_T_STROBE_NS + `NPA_CLK_PERIOD_NS - 1) / `NPA_CLK_PERIOD_NS)
`define NPA_WB_CYC ((`NPA_T_WB_NS + `NPA_CLK_PERIOD_NS - 1) / `NPA_CLK_PERIOD_NS)

`define NPA_OP_CMD 3'h0
`define NPA_OP_ADDR 3'h1
`define NPA_OP_WRITE 3'h2
`define NPA_OP_READ 3'h3
`define NPA_OP_WAIT 3'h4
`define NPA_OP_SCAN 3'h5

`define NPA_CMD_READ_SETUP 8'h00
`define NPA_CMD_READ_GO 8'h30
`define NPA_ADDR_CYCLES 2'h3
`define NPA_SPARE_COL_X8 12'h800
`define NPA_SPARE_COL_X16 12'h400
`define NPA_LAST_PAGE 6'h3F
`define NPA_LAST_BLOCK 10'h3FF
`define NPA_MARK_MAX_ONES 4'h3

`define NPA_FIFO_WIDTH 17
`define NPA_FIFO_DEPTH 32
`define NPA_FIFO_AW 5

`endif

// ==== verilog/npa_fifo.v ====
// Parameterised first-word-fall-through FIFO with registered read data
`timescale 1ns/1ps
`default_nettype none
module npa_fifo #(
  parameter W = 17,
  parameter D = 32,
  parameter AW = 5
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [W-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [W-1:0] o_out_data
);
  reg [W-1:0] mem_q [0:D-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  reg [W-1:0] out_q;
  reg out_valid_q;
  wire mem_full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire mem_empty = (wp_q == rp_q);
  wire push = i_in_valid && !mem_full;
  wire load = !mem_empty && (!out_valid_q || i_out_ready);

  assign o_in_ready = !mem_full;
  assign o_out_valid = out_valid_q;
  assign o_out_data = out_q;

  always @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= i_in_data;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
      out_q <= {W{1'b0}};
      out_valid_q <= 1'b0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (load) begin
        out_q <= mem_q[rp_q[AW-1:0]];
        out_valid_q <= 1'b1;
        rp_q <= rp_q + 1'b1;
      end else if (i_out_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end
endmodule // npa_fifo
`default_nettype wire

// ==== tb/npa_host_props.sv ====
// Port-level assertions for the NAND host sequencer
`timescale 1ns/1ps
`default_nettype none
module npa_host_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_x16,
  input wire logic i_wp_release,
  input wire logic i_op_valid,
  input wire logic o_op_ready,
  input wire logic [2:0] i_op_code,
  input wire logic o_busy,
  input wire logic o_ce_n,
  input wire logic o_cle,
  input wire logic o_ale,
  input wire logic o_we_n,
  input wire logic o_read_strobe_n,
  input wire logic o_wp_n,
  input wire logic i_ready_busy,
  input wire logic i_rd_ready,
  input wire logic o_rd_valid,
  input wire logic o_rd_bad,
  input wire logic [15:0] o_rd_data,
  input wire logic [7:0] o_io_low_byte,
  input wire logic o_io_low_byte_oe,
  input wire logic o_io_high_byte_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Counts write strobe rises while the address latch is held open
  logic we_q;
  logic [2:0] ale_cnt_q;
  always_ff @(posedge i_clk) begin
    we_q <= o_we_n;
    if (!i_rst_n || !o_ale) begin
      ale_cnt_q <= 3'h0;
    end else if (o_we_n && !we_q) begin
      ale_cnt_q <= ale_cnt_q + 3'h1;
    end
  end
  a_lane_free_read: assert property ((o_io_low_byte_oe || o_io_high_byte_oe) |-> o_read_strobe_n)
    else $error("host drives lanes during read strobe");
  a_latch_excl: assert property (!(o_cle && o_ale) && (o_we_n || o_read_strobe_n))
    else $error("latch enables or strobes overlap");
  a_high_lane_data: assert property (o_io_high_byte_oe |-> i_x16 && !o_cle && !o_ale)
    else $error("high lanes used outside x16 data");
  a_latch_edge: assert property ($rose(o_we_n) |-> !o_ce_n && o_io_low_byte_oe && $stable(o_io_low_byte))
    else $error("write strobe rise without stable driven byte");
  a_cmd_cycle: assert property ($rose(o_cle) |-> !o_we_n ##1 (o_we_n && o_cle))
    else $error("command latch without a strobe rise");
  a_addr_four: assert property ($fell(o_ale) |-> ale_cnt_q == 3'h4)
    else $error("address phase not four cycles");
  a_idle_deselect: assert property (o_op_ready |-> o_ce_n)
    else $error("device selected while idle");
  a_wp_follow: assert property (!i_wp_release |=> !o_wp_n)
    else $error("write protect released without request");
  a_scan_protect: assert property (i_op_valid && o_op_ready && i_op_code == 3'h5 |=> !o_wp_n [*8])
    else $error("write protect not held during scan");
  a_busy_no_read: assert property (!i_ready_busy |=> o_read_strobe_n)
    else $error("read strobe while device busy");
  a_rd_hold: assert property (o_rd_valid && !i_rd_ready |=> o_rd_valid && $stable(o_rd_data))
    else $error("read word changed before taken");
  c_bad_entry: cover property (o_rd_valid && o_rd_bad);
  c_high_lane: cover property (o_io_high_byte_oe && !o_we_n);
  c_full_stall: cover property (o_rd_valid && !i_rd_ready && o_busy);
endmodule // npa_host_chk
bind npa_host npa_host_chk chk (.i_clk, .i_rst_n, .i_x16, .i_wp_release, .i_op_valid, .o_op_ready,
  .i_op_code, .o_busy, .o_ce_n, .o_cle, .o_ale, .o_we_n, .o_read_strobe_n, .o_wp_n, .i_ready_busy,
  .i_rd_ready, .o_rd_valid, .o_rd_bad, .o_rd_data, .o_io_low_byte, .o_io_low_byte_oe,
  .o_io_high_byte_oe);
`default_nettype wire

// ==== tb/npa_dev_model.sv ====
// Behavioural NAND device as seen from the host pins
`timescale 1ns/1ps
`default_nettype none
module npa_dev_model #(
  parameter int BUSY_CYC = 6
) (
  input wire logic i_clk,
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_read_strobe_n,
  input wire logic i_wp_n,
  input wire logic [15:0] i_io,
  output logic o_rb_low,
  output logic [15:0] o_dout
);
  logic [7:0] cmd_q;
  logic [7:0] adr_q [4];
  logic [15:0] dat_q;
  logic [2:0] acnt_q = 3'h0;
  logic [11:0] col_q = 12'h000;
  int busy_q = 0;
  int prog_q = 0;
  int rd_q = 0;
  // Unselected device ignores every strobe
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle) begin
      cmd_q = i_io[7:0];
      if (cmd_q == 8'h00 || cmd_q == 8'h80) acnt_q = 3'h0;
      if (cmd_q == 8'h30) col_q = {adr_q[1][3:0], adr_q[0]};
      // A protected program is dropped, yet still looks accepted on the bus
      if (cmd_q == 8'h10 && i_wp_n) prog_q++;
      if (cmd_q == 8'h30 || (cmd_q == 8'h10 && i_wp_n)) busy_q = BUSY_CYC;
    end else if (!i_ce_n && i_ale) begin
      adr_q[acnt_q[1:0]] = i_io[7:0];
      acnt_q++;
    end else if (!i_ce_n) begin
      dat_q = i_io;
    end
  end
  // Non-blocking so the host never races the ready line at a clock edge
  always @(posedge i_clk) if (busy_q > 0) busy_q <= busy_q - 1;
  always @(posedge i_read_strobe_n) begin
    if (!i_ce_n) begin
      col_q++;
      rd_q++;
    end
  end
  assign o_rb_low = busy_q > 0;
  function automatic logic [7:0] rd_byte(input logic [11:0] c);
    logic [9:0] b;
    b = {adr_q[3], adr_q[2][7:6]};
    rd_byte = c[7:0] ^ 8'h5A;
    // Blocks 1, 2 and 5 carry defect marks; 3 and 4 are marginal but good
    if (c == 12'h000 || c == 12'h800) begin
      case ({b, adr_q[2][5:0] == 6'h3F, c == 12'h000})
        12'h005: rd_byte = 8'h00;
        12'h00A: rd_byte = 8'h07;
        12'h00D: rd_byte = 8'h0F;
        12'h010: rd_byte = 8'hFE;
        12'h017: rd_byte = 8'h80;
        default: rd_byte = 8'hFF;
      endcase
    end
  endfunction
  // Outside a read strobe the lanes show the complement of the current word, never stale data
  always_comb begin
    o_dout = {col_q[7:0], rd_byte(col_q)};
    if (i_ce_n || i_read_strobe_n) o_dout = ~o_dout;
  end
endmodule // npa_dev_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the NAND host sequencer against a device model
`timescale 1ns/1ps
`default_nettype none
`include "npa_consts.vh"
module tb_top;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_x16 = 1'h0, i_wp_release = 1'h0, i_op_valid = 1'h0;
  logic i_wr_valid = 1'h0, i_rd_ready = 1'h0;
  logic [2:0] i_op_code = 3'h0;
  logic [7:0] i_op_byte = 8'h00;
  logic [11:0] i_op_col = 12'h000, i_op_count = 12'h000;
  logic [15:0] i_op_row = 16'h0000, i_wr_data = 16'h0000;
  wire o_op_ready, o_wr_ready, o_rd_valid, o_rd_bad, o_busy, o_ce_n, o_cle, o_ale, o_we_n;
  wire o_read_strobe_n, o_wp_n, o_io_low_byte_oe, o_io_high_byte_oe, rb_low, i_ready_busy;
  wire [7:0] o_io_low_byte, o_io_high_byte;
  wire [15:0] o_rd_data, dev_dout, io;
  int n_fail = 0, n_compared = 0, cyc = 0;
  // Open-drain ready line with pull-up; lanes resolved from both drivers
  assign i_ready_busy = !rb_low;
  assign io[7:0] = o_io_low_byte_oe ? o_io_low_byte : dev_dout[7:0];
  assign io[15:8] = o_io_high_byte_oe ? o_io_high_byte : dev_dout[15:8];
  npa_host uut (.i_clk, .i_rst_n, .i_x16, .i_wp_release, .i_op_valid, .o_op_ready, .i_op_code,
    .i_op_byte, .i_op_col, .i_op_row, .i_op_count, .i_wr_valid, .o_wr_ready, .i_wr_data,
    .o_rd_valid, .i_rd_ready, .o_rd_data, .o_rd_bad, .o_busy, .o_ce_n, .o_cle, .o_ale, .o_we_n,
    .o_read_strobe_n, .o_wp_n, .i_ready_busy, .i_io_low_byte(io[7:0]), .o_io_low_byte,
    .o_io_low_byte_oe, .i_io_high_byte(io[15:8]), .o_io_high_byte, .o_io_high_byte_oe);
  npa_dev_model dev (.i_clk, .i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
    .i_read_strobe_n(o_read_strobe_n), .i_wp_n(o_wp_n), .i_io(io), .o_rb_low(rb_low),
    .o_dout(dev_dout));
  initial forever #25 i_clk = ~i_clk;
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic op(input logic [2:0] c, input logic [7:0] b = 8'h00,
      input logic [11:0] col = 12'h000, input logic [15:0] row = 16'h0000,
      input logic [11:0] n = 12'h000);
    i_op_valid <= 1'h1;
    i_op_code <= c;
    i_op_byte <= b;
    i_op_col <= col;
    i_op_row <= row;
    i_op_count <= n;
    do @(posedge i_clk); while (o_op_ready !== 1'h1);
    i_op_valid <= 1'h0;
  endtask
  task automatic idle();
    do @(posedge i_clk); while (o_op_ready !== 1'h1);
  endtask
  task automatic run(input logic [2:0] c, input logic [7:0] b = 8'h00,
      input logic [11:0] col = 12'h000, input logic [15:0] row = 16'h0000);
    op(c, b, col, row);
    idle();
  endtask
  // Valid stays up across words so it is never lowered and raised in one step
  task automatic wr(input logic [15:0] d, input int n);
    i_wr_valid <= 1'h1;
    for (int i = 0; i < n; i++) begin
      i_wr_data <= d + 16'(i);
      do @(posedge i_clk); while (o_wr_ready !== 1'h1);
    end
    i_wr_valid <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] d, input logic bad);
    do @(posedge i_clk); while (o_rd_valid !== 1'h1);
    chk({o_rd_bad, bad ? {6'h00, o_rd_data[9:0]} : o_rd_data}, {bad, d}, "buffer word");
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge i_clk);
    chk({o_ce_n, o_we_n, o_read_strobe_n, o_wp_n, o_io_low_byte_oe, o_op_ready}, 6'h39, "reset");
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    // Pass 0: x16, protected program; pass 1: x8, released program
    for (int k = 0; k < 2; k++) begin
      i_x16 <= k == 0;
      i_wp_release <= k == 1;
      @(posedge i_clk);
      run(`NPA_OP_CMD, 8'h80);
      run(`NPA_OP_ADDR, 8'h00, k ? 12'hFAB : 12'h7FF, k ? 16'h1234 : 16'hBEEF);
      chk({dev.adr_q[0], dev.adr_q[1], dev.adr_q[2], dev.adr_q[3]}, k ? 32'hAB0F3412 : 32'hFF07EFBE, "addr");
      chk(dev.acnt_q, 3'h4, "address cycles");
      op(`NPA_OP_WRITE, 8'h00, 12'h000, 16'h0000, k ? 12'h001 : 12'h002);
      wr(16'hC3A1, k ? 1 : 2);
      idle();
      chk(k ? dev.dat_q[7:0] : dev.dat_q, k ? 16'h00A1 : 16'hC3A2, "data word");
      run(`NPA_OP_CMD, 8'h10);
      run(`NPA_OP_WAIT);
      chk({o_wp_n, i_ready_busy}, {k[0], 1'h1}, "protect and ready");
      chk(dev.prog_q, k, "programs done");
      $display("write path pass %0d done", k);
    end
    run(`NPA_OP_CMD, `NPA_CMD_READ_SETUP);
    run(`NPA_OP_ADDR, 8'h00, 12'hFAB, 16'h1234);
    run(`NPA_OP_CMD, `NPA_CMD_READ_GO);
    run(`NPA_OP_WAIT);
    // Reader stalls so the buffer fills and the host must stop strobing
    op(`NPA_OP_READ, 8'h00, 12'h000, 16'h0000, 12'h028);
    repeat (300) @(posedge i_clk);
    chk({o_busy, o_rd_valid, dev.rd_q < 40}, 3'h7, "stall on full buffer");
    i_rd_ready <= 1'h1;
    for (int i = 0; i < 40; i++) rd(16'(8'(12'hFAB + i) ^ 8'h5A), 1'h0);
    idle();
    chk(dev.rd_q, 40, "read strobes");
    i_x16 <= 1'h1;
    op(`NPA_OP_READ, 8'h00, 12'h000, 16'h0000, 12'h002);
    for (int i = 0; i < 2; i++) rd({2{8'(12'hFD3 + i)}} ^ 16'h005A, 1'h0);
    idle();
    i_x16 <= 1'h0;
    op(3'h6);
    @(posedge i_clk);
    chk({o_ce_n, o_op_ready, o_busy}, 3'h6, "dropped op");
    $display("buffered read done");
    op(`NPA_OP_SCAN);
    rd(16'h0001, 1'h1);
    rd(16'h0002, 1'h1);
    rd(16'h0005, 1'h1);
    chk(o_wp_n, 1'h0, "protect during scan");
    i_rst_n <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    chk({o_busy, o_ce_n, o_rd_valid}, 3'h2, "reset mid scan");
    $display("scan and abort done");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
